/* rtl/mcu_subset_core.sv */
// instruction subset execution core with register port
//
// Behaviour
// RQ1: halt clears watchdog count and prescaler, takes one cycle, then enters halt.
// RQ2: halt sets timeout flag, clears powerdown flag, leaves other flags alone.
// RQ3: immediate subtract stores constant minus work, updates zero, nibble borrow, borrow.
// RQ4: nibble exchange swaps the two nibbles of the file operand in one cycle.
// RQ5: target select zero writes work register, one writes the file location.
// RQ6: timer0 mode load copies work into timer0 mode, flags untouched.
// RQ7: timer0 mode read copies timer0 mode into work, flags untouched.
// RQ8: table read addresses rom with pointer low bits over work, two cycles.
// RQ9: table read puts fetched word bits 13:8 into table high data.
// RQ10: register xor combines work and file, routed by target, zero only.
// RQ11: immediate xor combines work and constant into work, zero only.
// RQ12: borrow flag set when no borrow; zero flag set on zero result.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module mcu_subset_core
    import mcu_subset_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        instr_valid_i,
    input  wire logic [2:0]  instr_op_i,
    input  wire logic [7:0]  instr_imm_i,
    input  wire logic        instr_target_i,
    input  wire logic [6:0]  file_addr_i,
    input  wire logic [7:0]  file_data_i,
    output logic             instr_ready_o,
    output logic             file_we_o,
    output logic      [6:0]  file_addr_o,
    output logic      [7:0]  file_wdata_o,
    output logic             rom_rd_o,
    output logic      [10:0] rom_addr_o,
    input  wire logic [13:0] rom_data_i,
    input  wire logic        wake_i,
    output logic             halt_o,
    output logic             wdt_clear_o,
    output logic      [7:0]  timer0_mode_o,
    input  wire logic [7:0]  bus_addr_i,
    input  wire logic [7:0]  bus_wdata_i,
    input  wire logic        bus_wr_i,
    input  wire logic        bus_rd_i,
    output logic      [7:0]  bus_rdata_o
);
    typedef enum logic [1:0] {ST_RUN, ST_TABLE, ST_HALT} core_state_e;

    core_state_e state;
    logic [7:0]  work_register;
    logic [2:0]  table_high_pointer;
    logic [5:0]  table_high_data;
    logic [7:0]  watchdog_count;
    logic [7:0]  watchdog_prescaler;
    logic        borrow_flag;
    logic        nibble_borrow_flag;
    logic        zero_flag;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic [7:0]  alu_result;
    logic        alu_zero;
    logic        alu_borrow_not;
    logic        alu_nibble_borrow;
    logic        wake_level;
    logic        accept;
    logic        is_halt;
    logic        is_sub;
    logic        is_swap;
    logic        is_t0_load;
    logic        is_t0_read;
    logic        is_table;
    logic        is_xor_reg;
    logic        is_xor_imm;
    logic        to_file;
    logic        wr_work;
    logic        wr_status;
    logic [7:0]  status_word;

    exec_alu u_alu
    (
        .op_i            (instr_op_i),
        .work_i          (work_register),
        .imm_i           (instr_imm_i),
        .file_i          (file_data_i),
        .result_o        (alu_result),
        .zero_o          (alu_zero),
        .borrow_not_o    (alu_borrow_not),
        .nibble_borrow_o (alu_nibble_borrow)
    );

    pin_sync3 u_wake_sync
    (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (wake_i),
        .level_o   (wake_level)
    );

    // decode of the accepted instruction
    assign accept     = instr_valid_i && instr_ready_o;
    assign is_halt    = accept && (instr_op_i == OP_HALT);
    assign is_sub     = accept && (instr_op_i == OP_IMM_SUBTRACT);
    assign is_swap    = accept && (instr_op_i == OP_NIBBLE_EXCH);
    assign is_t0_load = accept && (instr_op_i == OP_T0_MODE_LOAD);
    assign is_t0_read = accept && (instr_op_i == OP_T0_MODE_READ);
    assign is_table   = accept && (instr_op_i == OP_ROM_TABLE);
    assign is_xor_reg = accept && (instr_op_i == OP_REG_XOR);
    assign is_xor_imm = accept && (instr_op_i == OP_IMM_XOR);
    assign to_file    = (is_swap || is_xor_reg) && (instr_target_i == TARGET_FILE); // [RQ5]
    assign wr_work    = bus_wr_i && (bus_addr_i == ADDR_WORK);
    assign wr_status  = bus_wr_i && (bus_addr_i == ADDR_STATUS);

    assign status_word = {2'b00, (state == ST_HALT), timeout_flag, powerdown_flag,
                          zero_flag, nibble_borrow_flag, borrow_flag};

    // sequencing: run, two-cycle table fetch, halt
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state         <= ST_RUN;
            instr_ready_o <= 1'b1;
            halt_o        <= 1'b0;
        end
        else
        begin
            case (state)
                ST_RUN:
                begin
                    if (is_table)
                    begin
                        state         <= ST_TABLE; // [RQ8]
                        instr_ready_o <= 1'b0;
                    end
                    else if (is_halt)
                    begin
                        state         <= ST_HALT; // [RQ1]
                        instr_ready_o <= 1'b0;
                        halt_o        <= 1'b1;
                    end
                end
                ST_TABLE:
                begin
                    state         <= ST_RUN;
                    instr_ready_o <= 1'b1;
                end
                ST_HALT:
                begin
                    if (wake_level)
                    begin
                        state         <= ST_RUN;
                        instr_ready_o <= 1'b1;
                        halt_o        <= 1'b0;
                    end
                end
                default:
                begin
                    state         <= ST_RUN;
                    instr_ready_o <= 1'b1;
                    halt_o        <= 1'b0;
                end
            endcase
        end
    end

    // work register
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            work_register <= RST_WORK;
        else if (state == ST_TABLE)
            work_register <= rom_data_i[7:0]; // [RQ8]
        else if ((is_sub || is_xor_imm) || ((is_swap || is_xor_reg) && !to_file))
            work_register <= alu_result; // [RQ3] [RQ5] [RQ11]
        else if (is_t0_read)
            work_register <= timer0_mode_o; // [RQ7]
        else if (wr_work)
            work_register <= bus_wdata_i;
    end

    // file write-back port
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            file_we_o    <= 1'b0;
            file_addr_o  <= 7'h00;
            file_wdata_o <= 8'h00;
        end
        else
        begin
            file_we_o <= to_file; // [RQ5]
            if (to_file)
            begin
                file_addr_o  <= file_addr_i;
                file_wdata_o <= alu_result; // [RQ4] [RQ10]
            end
        end
    end

    // timer0 mode register
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            timer0_mode_o <= RST_T0_MODE;
        else if (is_t0_load)
            timer0_mode_o <= work_register; // [RQ6]
        else if (bus_wr_i && (bus_addr_i == ADDR_T0_MODE))
            timer0_mode_o <= bus_wdata_i;
    end

    // table pointer, fetch strobe and high data
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            table_high_pointer <= RST_TBL_PTR;
            table_high_data    <= RST_TBL_DATA;
            rom_rd_o           <= 1'b0;
            rom_addr_o         <= 11'h000;
        end
        else
        begin
            if (bus_wr_i && (bus_addr_i == ADDR_TBL_PTR))
                table_high_pointer <= bus_wdata_i[2:0];
            rom_rd_o <= is_table;
            if (is_table)
                rom_addr_o <= {table_high_pointer, work_register}; // [RQ8]
            if (state == ST_TABLE)
                table_high_data <= rom_data_i[13:8]; // [RQ9]
        end
    end

    // arithmetic and power flags; instruction updates win over bus writes
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            borrow_flag        <= 1'b0;
            nibble_borrow_flag <= 1'b0;
            zero_flag          <= 1'b0;
            timeout_flag       <= RST_TIMEOUT;
            powerdown_flag     <= RST_POWERDOWN;
        end
        else
        begin
            if (wr_status)
            begin
                borrow_flag        <= bus_wdata_i[ST_BORROW_NOT];
                nibble_borrow_flag <= bus_wdata_i[ST_NIBBLE_BRW];
                zero_flag          <= bus_wdata_i[ST_ZERO];
                timeout_flag       <= bus_wdata_i[ST_TIMEOUT];
                powerdown_flag     <= bus_wdata_i[ST_POWERDOWN];
            end
            if (is_sub)
            begin
                borrow_flag        <= alu_borrow_not; // [RQ12]
                nibble_borrow_flag <= alu_nibble_borrow; // [RQ3]
                zero_flag          <= alu_zero; // [RQ12]
            end
            if (is_xor_reg || is_xor_imm)
                zero_flag <= alu_zero; // [RQ10] [RQ11]
            if (is_halt)
            begin
                timeout_flag   <= 1'b1; // [RQ2]
                powerdown_flag <= 1'b0; // [RQ2]
            end
        end
    end

    // watchdog prescaler and counter, cleared by halt
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            watchdog_prescaler <= WDT_CLEAR;
            watchdog_count     <= WDT_CLEAR;
            wdt_clear_o        <= 1'b0;
        end
        else
        begin
            wdt_clear_o <= is_halt;
            if (is_halt)
            begin
                watchdog_prescaler <= WDT_CLEAR; // [RQ1]
                watchdog_count     <= WDT_CLEAR; // [RQ1]
            end
            else
            begin
                watchdog_prescaler <= watchdog_prescaler + 8'h01;
                if (watchdog_prescaler == 8'hff)
                    watchdog_count <= watchdog_count + 8'h01;
            end
        end
    end

    // register read port, data valid one cycle after strobe
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            bus_rdata_o <= 8'h00;
        else if (!bus_rd_i)
            bus_rdata_o <= 8'h00;
        else if (bus_addr_i == ADDR_WORK)
            bus_rdata_o <= work_register;
        else if (bus_addr_i == ADDR_STATUS)
            bus_rdata_o <= status_word;
        else if (bus_addr_i == ADDR_T0_MODE)
            bus_rdata_o <= timer0_mode_o;
        else if (bus_addr_i == ADDR_TBL_PTR)
            bus_rdata_o <= {5'h00, table_high_pointer};
        else if (bus_addr_i == ADDR_TBL_DATA)
            bus_rdata_o <= {2'b00, table_high_data};
        else if (bus_addr_i == ADDR_WDT_COUNT)
            bus_rdata_o <= watchdog_count;
        else if (bus_addr_i == ADDR_WDT_PRESC)
            bus_rdata_o <= watchdog_prescaler;
        else
            bus_rdata_o <= 8'h00;
    end

    default clocking chk_clk @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    halt_watchdog_a: assert property (is_halt |=> watchdog_count == 8'h00 && // [RQ1]
        watchdog_prescaler == 8'h00 && halt_o && !instr_ready_o)
        else $error("halt did not clear watchdog or enter halt");
    halt_flags_a: assert property (is_halt && !wr_status |=> timeout_flag && // [RQ2]
        !powerdown_flag && $stable(zero_flag) && $stable(borrow_flag))
        else $error("halt flag update wrong");
    sub_result_a: assert property (is_sub |=> // [RQ3]
        work_register == 8'($past(instr_imm_i) - $past(work_register)))
        else $error("subtract result wrong");
    swap_file_a: assert property (is_swap && to_file && !wr_status |=> file_we_o && // [RQ4]
        file_wdata_o == $past({file_data_i[3:0], file_data_i[7:4]}) && $stable(zero_flag))
        else $error("nibble exchange wrong");
    target_work_a: assert property ((is_swap || is_xor_reg) && !to_file |=> // [RQ5]
        !file_we_o && work_register == (($past(instr_op_i) == OP_REG_XOR) ?
        $past(work_register ^ file_data_i) : $past({file_data_i[3:0], file_data_i[7:4]})))
        else $error("work target wrote file");
    t0_load_a: assert property (is_t0_load && !wr_status |=> // [RQ6]
        timer0_mode_o == $past(work_register) && $stable(zero_flag) && $stable(borrow_flag))
        else $error("timer0 mode load wrong");
    t0_read_a: assert property (is_t0_read |=> work_register == $past(timer0_mode_o)) // [RQ7]
        else $error("timer0 mode read wrong");
    table_fetch_a: assert property (is_table |=> rom_rd_o && !instr_ready_o && // [RQ8]
        rom_addr_o == $past({table_high_pointer, work_register})
        ##1 instr_ready_o && work_register == $past(rom_data_i[7:0]))
        else $error("table read fetch wrong");
    table_high_a: assert property (rom_rd_o |=> table_high_data == $past(rom_data_i[13:8])) // [RQ9]
        else $error("table high data wrong");
    xor_reg_a: assert property (is_xor_reg && to_file |=> file_we_o && // [RQ10]
        file_wdata_o == $past(work_register ^ file_data_i) && zero_flag == (file_wdata_o == 8'h00))
        else $error("register xor wrong");
    xor_imm_a: assert property (is_xor_imm && !wr_status |=> // [RQ11]
        work_register == $past(work_register ^ instr_imm_i) && $stable(borrow_flag))
        else $error("immediate xor wrong");
    borrow_zero_a: assert property (is_sub && !wr_status |=> // [RQ12]
        borrow_flag == $past(instr_imm_i >= work_register) && zero_flag == (work_register == 8'h00))
        else $error("subtract flags wrong");

    halt_wake_c: cover property (is_halt ##[1:20] instr_ready_o);
    table_read_c: cover property (is_table ##2 accept);
    sub_borrow_c: cover property (is_sub ##1 !borrow_flag);
endmodule

/* include/mcu_subset_pkg.sv */
// constants shared by the instruction subset core
package mcu_subset_pkg;
    // widths
    localparam int DATA_W     = 8;
    localparam int ROM_W      = 14;
    localparam int ROM_ADDR_W = 11;
    localparam int PTR_W      = 3;
    localparam int HIGH_W     = 6;
    localparam int FILE_W     = 7;
    localparam int BUS_ADDR_W = 8;
    localparam int OP_W       = 3;

    // instruction codes on the issue port
    localparam logic [2:0] OP_HALT          = 3'h0;
    localparam logic [2:0] OP_IMM_SUBTRACT  = 3'h1;
    localparam logic [2:0] OP_NIBBLE_EXCH   = 3'h2;
    localparam logic [2:0] OP_T0_MODE_LOAD  = 3'h3;
    localparam logic [2:0] OP_T0_MODE_READ  = 3'h4;
    localparam logic [2:0] OP_ROM_TABLE     = 3'h5;
    localparam logic [2:0] OP_REG_XOR       = 3'h6;
    localparam logic [2:0] OP_IMM_XOR       = 3'h7;

    // target select values
    localparam logic TARGET_WORK = 1'b0;
    localparam logic TARGET_FILE = 1'b1;

    // register offsets
    localparam logic [7:0] ADDR_WORK      = 8'h00;
    localparam logic [7:0] ADDR_STATUS    = 8'h04;
    localparam logic [7:0] ADDR_T0_MODE   = 8'h08;
    localparam logic [7:0] ADDR_TBL_PTR   = 8'h0c;
    localparam logic [7:0] ADDR_TBL_DATA  = 8'h10;
    localparam logic [7:0] ADDR_WDT_COUNT = 8'h14;
    localparam logic [7:0] ADDR_WDT_PRESC = 8'h18;

    // status field positions
    localparam int ST_BORROW_NOT = 0;
    localparam int ST_NIBBLE_BRW = 1;
    localparam int ST_ZERO       = 2;
    localparam int ST_POWERDOWN  = 3;
    localparam int ST_TIMEOUT    = 4;
    localparam int ST_HALTED     = 5;

    // reset values
    localparam logic [7:0] RST_WORK      = 8'h00;
    localparam logic [7:0] RST_T0_MODE   = 8'h00;
    localparam logic [2:0] RST_TBL_PTR   = 3'h0;
    localparam logic [5:0] RST_TBL_DATA  = 6'h00;
    localparam logic       RST_TIMEOUT   = 1'b1;
    localparam logic       RST_POWERDOWN = 1'b1;
    localparam logic [7:0] WDT_CLEAR     = 8'h00;
endpackage

/* rtl/exec_alu.sv */
// combinational datapath for subtract, exchange and exclusive-or
`timescale 1ns/1ps
module exec_alu
    import mcu_subset_pkg::*;
(
    input  wire logic [2:0] op_i,
    input  wire logic [7:0] work_i,
    input  wire logic [7:0] imm_i,
    input  wire logic [7:0] file_i,
    output logic      [7:0] result_o,
    output logic            zero_o,
    output logic            borrow_not_o,
    output logic            nibble_borrow_o
);
    always_comb
    begin
        result_o        = work_i;
        borrow_not_o    = 1'b0;
        nibble_borrow_o = 1'b0;
        case (op_i)
            OP_IMM_SUBTRACT:
            begin
                result_o        = imm_i - work_i;               // [RQ3]
                borrow_not_o    = (imm_i >= work_i);            // [RQ12]
                nibble_borrow_o = (imm_i[3:0] >= work_i[3:0]);  // [RQ3]
            end
            OP_NIBBLE_EXCH:  result_o = {file_i[3:0], file_i[7:4]}; // [RQ4]
            OP_REG_XOR:      result_o = work_i ^ file_i;            // [RQ10]
            OP_IMM_XOR:      result_o = work_i ^ imm_i;             // [RQ11]
            default:         result_o = work_i;
        endcase
        zero_o = (result_o == 8'h00); // [RQ12]
    end
endmodule

/* rtl/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3
(
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage1  <= 1'b0;
            stage2  <= 1'b0;
            stage3  <= 1'b0;
            level_o <= 1'b0;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                level_o <= stage3;
        end
    end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the instruction subset core
`timescale 1ns/1ps
module tb_top;
    import mcu_subset_pkg::*;
    logic        sys_clk_i      = 1'b0;
    logic        reset_n_i      = 1'b0;
    logic        instr_valid_i  = 1'b0;
    logic [2:0]  instr_op_i     = 3'h0;
    logic [7:0]  instr_imm_i    = 8'h00;
    logic        instr_target_i = 1'b0;
    logic [6:0]  file_addr_i    = 7'h00;
    logic [7:0]  file_data_i    = 8'h00;
    logic [13:0] rom_data_i;
    logic        wake_i         = 1'b0;
    logic [7:0]  bus_addr_i     = 8'h00;
    logic [7:0]  bus_wdata_i    = 8'h00;
    logic        bus_wr_i       = 1'b0;
    logic        bus_rd_i       = 1'b0;
    logic        instr_ready_o, file_we_o, rom_rd_o, halt_o, wdt_clear_o;
    logic [6:0]  file_addr_o;
    logic [7:0]  file_wdata_o, timer0_mode_o, bus_rdata_o;
    logic [10:0] rom_addr_o;
    logic [7:0]  rd_q[$];
    logic [14:0] fw_q[$];
    logic [10:0] ra_q[$];
    logic        rd_seen = 1'b0;
    logic [31:0] rnd = 32'ha1d361be;
    logic [7:0]  mdl_work = 8'h00;
    logic [7:0]  mdl_st = 8'h18;
    int          err_total = 0;
    int          n_compared = 0;
    int          wdt_pulses = 0;

    mcu_subset_core u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
        .instr_imm_i(instr_imm_i), .instr_target_i(instr_target_i),
        .file_addr_i(file_addr_i), .file_data_i(file_data_i),
        .instr_ready_o(instr_ready_o), .file_we_o(file_we_o),
        .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
        .rom_rd_o(rom_rd_o), .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i),
        .wake_i(wake_i), .halt_o(halt_o), .wdt_clear_o(wdt_clear_o),
        .timer0_mode_o(timer0_mode_o), .bus_addr_i(bus_addr_i),
        .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_rdata_o(bus_rdata_o));

    // combinational program rom
    assign rom_data_i = {rom_addr_o[10:5], rom_addr_o[7:0] ^ 8'h5a};

    always #5 sys_clk_i = ~sys_clk_i;

    task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (rd_q.size() + fw_q.size() + ra_q.size() != 0)
        begin
            err_total++;
            $display("[FAIL] %0t expected results never appeared", $time);
        end
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // output watcher
    always @(posedge sys_clk_i) rd_seen <= bus_rd_i;
    always @(negedge sys_clk_i)
    begin
        if (reset_n_i && rd_seen)
            chk(bus_rdata_o, (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx);
        if (reset_n_i && file_we_o)
            chk({file_addr_o, file_wdata_o}, (fw_q.size() > 0) ? fw_q.pop_front() : 'x);
        if (reset_n_i && rom_rd_o)
        begin
            chk(rom_addr_o, (ra_q.size() > 0) ? ra_q.pop_front() : 'x);
            chk(instr_ready_o, 1'b0);
        end
        if (reset_n_i && wdt_clear_o)
            wdt_pulses++;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        err_total++;
        $display("[FAIL] %0t run timeout", $time);
        close_out();
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        bus_addr_i  <= a;
        bus_wdata_i <= d;
        bus_wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        bus_wr_i <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        @(posedge sys_clk_i);
        bus_addr_i <= a;
        bus_rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        bus_rd_i <= 1'b0;
    endtask

    task automatic wait_ready;
        int k;
        k = 0;
        @(negedge sys_clk_i);
        while (instr_ready_o !== 1'b1 && k < 50)
        begin
            @(negedge sys_clk_i);
            k++;
        end
        if (k >= 50)
        begin
            err_total++;
            $display("[FAIL] %0t ready never rose", $time);
        end
    endtask

    task automatic issue(input logic [2:0] op, input logic [7:0] imm, input logic tgt,
                         input logic [6:0] fa, input logic [7:0] fd);
        wait_ready();
        @(posedge sys_clk_i);
        instr_valid_i  <= 1'b1;
        instr_op_i     <= op;
        instr_imm_i    <= imm;
        instr_target_i <= tgt;
        file_addr_i    <= fa;
        file_data_i    <= fd;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
    endtask

    task automatic seed_work;
        rnd = lfsr(rnd);
        mdl_work = rnd[7:0];
        bus_wr(ADDR_WORK, mdl_work);
    endtask

    task automatic run_op(input logic [2:0] op, input logic [7:0] imm, input logic tgt);
        logic [7:0] r;
        rnd = lfsr(rnd);
        case (op)
            OP_IMM_SUBTRACT: r = imm - mdl_work;
            OP_NIBBLE_EXCH:  r = {imm[3:0], imm[7:4]};
            default:         r = imm ^ mdl_work;
        endcase
        if (op == OP_IMM_SUBTRACT)
        begin
            mdl_st[ST_BORROW_NOT] = imm >= mdl_work;
            mdl_st[ST_NIBBLE_BRW] = imm[3:0] >= mdl_work[3:0];
        end
        if (op != OP_NIBBLE_EXCH)
            mdl_st[ST_ZERO] = (r == 8'h00);
        if (tgt)
            fw_q.push_back({rnd[6:0], r});
        else
            mdl_work = r;
        issue(op, imm, tgt, rnd[6:0], imm);
        bus_rd(ADDR_WORK, mdl_work);
        bus_rd(ADDR_STATUS, mdl_st);
    endtask

    initial
    begin
        repeat (8) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        bus_rd(ADDR_WORK, RST_WORK);
        bus_rd(ADDR_STATUS, 8'h18);
        bus_rd(ADDR_T0_MODE, RST_T0_MODE);
        bus_rd(8'h1c, 8'h00);
        $display("test reset_values done");

        for (int i = 0; i < 8; i++)
        begin
            seed_work();
            rnd = lfsr(rnd);
            run_op(OP_IMM_SUBTRACT, (i == 0) ? mdl_work : (i == 1) ? mdl_work - 8'h01 :
                   rnd[15:8], 1'b0);
        end
        $display("test imm_subtract done");

        for (int i = 0; i < 6; i++)
        begin
            seed_work();
            rnd = lfsr(rnd);
            run_op(OP_IMM_XOR, (i == 0) ? mdl_work : rnd[15:8], 1'b0);
            run_op(OP_NIBBLE_EXCH, rnd[23:16], i[0]);
            run_op(OP_REG_XOR, (i < 2) ? mdl_work : rnd[31:24], i[0]);
        end
        $display("test file_operand_ops done");

        seed_work();
        issue(OP_T0_MODE_LOAD, 8'h00, 1'b0, 7'h00, 8'h00);
        @(negedge sys_clk_i);
        chk(timer0_mode_o, mdl_work);
        bus_rd(ADDR_T0_MODE, mdl_work);
        rnd = lfsr(rnd);
        bus_wr(ADDR_T0_MODE, rnd[7:0]);
        mdl_work = rnd[7:0];
        issue(OP_T0_MODE_READ, 8'h00, 1'b0, 7'h00, 8'h00);
        bus_rd(ADDR_WORK, mdl_work);
        bus_rd(ADDR_STATUS, mdl_st);
        $display("test timer0_mode done");

        bus_wr(ADDR_TBL_PTR, 8'h02);
        bus_wr(ADDR_WORK, 8'h34);
        ra_q.push_back(11'h234);
        issue(OP_ROM_TABLE, 8'h00, 1'b0, 7'h00, 8'h00);
        bus_rd(ADDR_WORK, 8'h34 ^ 8'h5a);
        bus_rd(ADDR_TBL_DATA, 8'h11);
        bus_rd(ADDR_STATUS, mdl_st);
        $display("test table_read done");

        bus_wr(ADDR_STATUS, 8'h0f);
        issue(OP_HALT, 8'h00, 1'b0, 7'h00, 8'h00);
        @(negedge sys_clk_i);
        chk(halt_o, 1'b1);
        bus_rd(ADDR_STATUS, 8'h37);
        bus_rd(ADDR_WDT_COUNT, WDT_CLEAR);
        chk(15'(wdt_pulses), 15'h0001);
        @(posedge sys_clk_i);
        wake_i <= 1'b1;
        wait_ready();
        chk(halt_o, 1'b0);
        bus_rd(ADDR_STATUS, 8'h17);
        $display("test halt_entry done");
        repeat (4) @(posedge sys_clk_i);
        close_out();
    end
endmodule
